// File: common/accel_reg_pkg.sv
package accel_reg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SAMPLE_W = 14;
   localparam int BUF_DEPTH_DEF = 32;

   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_X_HIGH = 8'h01;
   localparam logic [7:0] ADDR_X_LOW = 8'h02;
   localparam logic [7:0] ADDR_Y_HIGH = 8'h03;
   localparam logic [7:0] ADDR_Y_LOW = 8'h04;
   localparam logic [7:0] ADDR_Z_HIGH = 8'h05;
   localparam logic [7:0] ADDR_Z_LOW = 8'h06;
   localparam logic [7:0] ADDR_RSVD_LO = 8'h07;
   localparam logic [7:0] ADDR_RSVD_HI = 8'h08;
   localparam logic [7:0] ADDR_BUF_SETUP = 8'h09;
   localparam logic [7:0] ADDR_TRIG_SEL = 8'h0A;
   localparam logic [7:0] ADDR_SYS_MODE = 8'h0B;
   localparam logic [7:0] ADDR_INT_CAUSE = 8'h0C;
   localparam logic [7:0] ADDR_ID = 8'h0D;
   localparam logic [7:0] ADDR_RANGE_CFG = 8'h0E;
   localparam logic [7:0] ADDR_HP_CUTOFF = 8'h0F;
   localparam logic [7:0] ADDR_ORIENT_STATE = 8'h10;
   localparam logic [7:0] ADDR_ORIENT_CFG = 8'h11;
   localparam logic [7:0] ADDR_ORIENT_DEB = 8'h12;
   localparam logic [7:0] ADDR_BF_TRIP = 8'h13;
   localparam logic [7:0] ADDR_ORIENT_THS = 8'h14;
   localparam logic [7:0] ADDR_FM_CFG = 8'h15;
   localparam logic [7:0] ADDR_FM_SRC = 8'h16;
   localparam logic [7:0] ADDR_FM_THS = 8'h17;
   localparam logic [7:0] ADDR_FM_DEB = 8'h18;
   localparam logic [7:0] ADDR_SYS_CTRL1 = 8'h2A;
   localparam logic [7:0] ADDR_INT_MASK = 8'h2D;

   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ORIENT_CFG = 8'h80;
   localparam logic [7:0] RST_ORIENT_THS = 8'h1A;

   // field positions
   localparam int BUF_MODE_HI = 7;
   localparam int BUF_MODE_LO = 6;
   localparam int WMK_HI = 5;
   localparam int FAST_READ_BIT = 1;
   localparam int ACTIVE_BIT = 0;
   localparam int FM_LATCH_BIT = 7;
   localparam int FM_EVENT_BIT = 7;
   localparam int INT_DRDY_BIT = 0;
   localparam int INT_FM_BIT = 2;
   localparam int INT_BUF_BIT = 6;
   localparam int HIGH_SPLIT = 6;
   localparam int LOW_SHIFT = 2;

   localparam logic [1:0] BUF_MODE_OFF = 2'h0;
   localparam logic [1:0] BUF_MODE_CIRC = 2'h1;

   typedef enum logic [5:0] {
      SEL_XH = 6'h01,
      SEL_XL = 6'h02,
      SEL_YH = 6'h04,
      SEL_YL = 6'h08,
      SEL_ZH = 6'h10,
      SEL_ZL = 6'h20
   } buf_byte_t;

   function automatic logic isWritable(input logic [7:0] a);
      case (a)
         ADDR_BUF_SETUP, ADDR_TRIG_SEL, ADDR_RANGE_CFG, ADDR_HP_CUTOFF,
         ADDR_ORIENT_CFG, ADDR_ORIENT_DEB, ADDR_BF_TRIP, ADDR_ORIENT_THS,
         ADDR_FM_CFG, ADDR_FM_THS, ADDR_FM_DEB, ADDR_SYS_CTRL1,
         ADDR_INT_MASK: isWritable = 1'b1;
         default: isWritable = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] resetValue(input logic [7:0] a);
      case (a)
         ADDR_ORIENT_CFG: resetValue = RST_ORIENT_CFG;
         ADDR_ORIENT_THS: resetValue = RST_ORIENT_THS;
         default: resetValue = RST_ZERO;
      endcase
   endfunction
endpackage

// File: verilog/accel_addr_step.sv
`timescale 1ns/1ps
module accel_addr_step
   import accel_reg_pkg::*;
(
   input wire logic [7:0] curAddr, // address of the access just made
   input wire logic bufOn, // buffer mode field non-zero
   input wire logic fastRd, // high bytes only
   output logic [7:0] nextAddr // pointer after the access
);
   always_comb begin
      nextAddr = curAddr + 8'h01;
      if (curAddr >= ADDR_X_HIGH && curAddr <= ADDR_Z_LOW) begin
         if (bufOn && curAddr == ADDR_X_HIGH) begin
            nextAddr = ADDR_X_HIGH;
         end else if (!fastRd) begin
            if (curAddr == ADDR_Z_LOW) begin
               nextAddr = ADDR_STATUS;
            end
         end else if (!bufOn && (curAddr == ADDR_X_HIGH || curAddr == ADDR_Y_HIGH)) begin
            nextAddr = curAddr + 8'h02;
         end else begin
            nextAddr = ADDR_STATUS;
         end
      end
   end
endmodule // accel_addr_step

// File: verilog/accel_reg_autoinc_map.sv
`timescale 1ns/1ps
module accel_reg_autoinc_map
   import accel_reg_pkg::*;
#(
   parameter int BUF_DEPTH = BUF_DEPTH_DEF,
   parameter logic [7:0] DEVICE_ID = 8'h5C // arbitrary identifier value
)(
   input wire logic clk_sys, // 50 MHz system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic clkEn, // freezes all state while low
   input wire logic [7:0] regAddr, // register address
   input wire logic [7:0] regWrData, // write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   input wire logic burst, // access uses the auto-increment pointer
   output logic [7:0] regRdData, // read data, cycle after the read
   output logic [7:0] ptr, // auto-increment pointer
   input wire logic sampleValid, // new sample pulse
   input wire logic [13:0] sampleX, // x sample
   input wire logic [13:0] sampleY, // y sample
   input wire logic [13:0] sampleZ, // z sample
   input wire logic motionDetect, // real-time fall/motion detection
   input wire logic [5:0] motionDir, // direction of the motion event
   input wire logic [7:0] orientState, // orientation detector state
   output logic irq // level interrupt
);
   localparam int CNT_W = $clog2(BUF_DEPTH) + 1;
   localparam int PTR_W = $clog2(BUF_DEPTH);
   localparam int ENTRY_W = 3 * SAMPLE_W;

   logic [7:0] rwMem [0:63];
   logic [13:0] xSamp, ySamp, zSamp;
   logic [2:0] drFlag, owFlag;
   logic [ENTRY_W-1:0] bufMem [0:BUF_DEPTH-1];
   logic [PTR_W-1:0] wrIdx, rdIdx;
   logic [CNT_W-1:0] bufCnt;
   logic bufOvf;
   buf_byte_t bufSel;
   logic fmFlag;
   logic [7:0] intCause;
   logic [7:0] rdByte;
   logic [7:0] next_ptr;
   logic [7:0] accAddr;
   logic acc, rdAcc, wrAcc;
   logic bufOn, fastRd, latchOn, active;
   logic [1:0] bufMode;
   logic push, pop, bufFull, bufEmpty, wmkHit, bufLast;
   logic [ENTRY_W-1:0] headEntry;
   logic [7:0] statusByte, bufStatus, drStatus, fmSrc;

   assign acc = clkEn && (regRd || regWr);
   assign rdAcc = clkEn && regRd;
   assign wrAcc = clkEn && regWr;
   assign accAddr = burst ? ptr : regAddr;
   assign bufMode = rwMem[ADDR_BUF_SETUP[5:0]][BUF_MODE_HI:BUF_MODE_LO];
   assign bufOn = bufMode != BUF_MODE_OFF;
   assign fastRd = rwMem[ADDR_SYS_CTRL1[5:0]][FAST_READ_BIT];
   assign active = rwMem[ADDR_SYS_CTRL1[5:0]][ACTIVE_BIT];
   assign latchOn = rwMem[ADDR_FM_CFG[5:0]][FM_LATCH_BIT];

   accel_addr_step u_step (
      .curAddr(accAddr),
      .bufOn(bufOn),
      .fastRd(fastRd),
      .nextAddr(next_ptr)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ptr <= ADDR_STATUS;
      end else if (acc) begin
         ptr <= next_ptr;
      end
   end

   // writable registers only; read-only and reserved addresses drop the write
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < 64; i++) begin
            rwMem[i] <= resetValue(8'(i));
         end
      end else if (wrAcc && isWritable(accAddr)) begin
         rwMem[accAddr[5:0]] <= regWrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         xSamp <= '0;
         ySamp <= '0;
         zSamp <= '0;
      end else if (clkEn && sampleValid && active) begin
         xSamp <= sampleX;
         ySamp <= sampleY;
         zSamp <= sampleZ;
      end
   end

   // per-axis ready and overwrite flags; a new sample wins over a read clear of the ready flag, the overwrite flag still clears
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_axis
         logic clrAxis;
         assign clrAxis = rdAcc && !bufOn && accAddr == ADDR_X_HIGH + 8'(2 * g);
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               drFlag[g] <= 1'b0;
               owFlag[g] <= 1'b0;
            end else if (clkEn) begin
               if (sampleValid && active) begin
                  drFlag[g] <= 1'b1;
                  owFlag[g] <= drFlag[g] && !clrAxis ? 1'b1 : owFlag[g] && !clrAxis;
               end else if (clrAxis) begin
                  drFlag[g] <= 1'b0;
                  owFlag[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // sample buffer
   assign bufFull = bufCnt == CNT_W'(BUF_DEPTH);
   assign bufEmpty = bufCnt == '0;
   assign headEntry = bufMem[rdIdx];
   assign wmkHit = rwMem[ADDR_BUF_SETUP[5:0]][WMK_HI:0] != 6'h00 &&
                   bufCnt >= CNT_W'(rwMem[ADDR_BUF_SETUP[5:0]][WMK_HI:0]);
   assign bufLast = fastRd ? bufSel == SEL_ZH : bufSel == SEL_ZL;
   assign push = clkEn && sampleValid && active && bufOn &&
                 (!bufFull || bufMode == BUF_MODE_CIRC);
   assign pop = (rdAcc && bufOn && accAddr == ADDR_X_HIGH && !bufEmpty && bufLast) ||
                (push && bufFull);

   always_ff @(posedge clk_sys) begin
      if (push) begin
         bufMem[wrIdx] <= {sampleX, sampleY, sampleZ};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || (clkEn && !bufOn)) begin
         wrIdx <= '0;
         rdIdx <= '0;
         bufCnt <= '0;
      end else begin
         if (push) begin
            wrIdx <= wrIdx == PTR_W'(BUF_DEPTH - 1) ? '0 : wrIdx + 1'b1;
         end
         if (pop) begin
            rdIdx <= rdIdx == PTR_W'(BUF_DEPTH - 1) ? '0 : rdIdx + 1'b1;
         end
         if (push && !pop) begin
            bufCnt <= bufCnt + 1'b1;
         end else if (pop && !push) begin
            bufCnt <= bufCnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bufOvf <= 1'b0;
      end else if (clkEn) begin
         if (sampleValid && active && bufOn && bufFull) begin
            bufOvf <= 1'b1;
         end else if (!bufOn || (rdAcc && accAddr == ADDR_STATUS)) begin
            bufOvf <= 1'b0;
         end
      end
   end

   // byte sequencer for reads of the root pointer while buffering
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bufSel <= SEL_XH;
      end else if (clkEn) begin
         if (!bufOn || (acc && accAddr != ADDR_X_HIGH)) begin
            bufSel <= SEL_XH;
         end else if (rdAcc && accAddr == ADDR_X_HIGH && !bufEmpty) begin
            unique case (bufSel)
               SEL_XH: bufSel <= fastRd ? SEL_YH : SEL_XL;
               SEL_XL: bufSel <= SEL_YH;
               SEL_YH: bufSel <= fastRd ? SEL_ZH : SEL_YL;
               SEL_YL: bufSel <= SEL_ZH;
               SEL_ZH: bufSel <= fastRd ? SEL_XH : SEL_ZL;
               SEL_ZL: bufSel <= SEL_XH;
               default: bufSel <= SEL_XH;
            endcase
         end
      end
   end

   // fall/motion flag: latched until the source register is read, else live
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fmFlag <= 1'b0;
      end else if (clkEn) begin
         if (!latchOn) begin
            fmFlag <= motionDetect;
         end else if (motionDetect) begin
            fmFlag <= 1'b1;
         end else if (rdAcc && accAddr == ADDR_FM_SRC) begin
            fmFlag <= 1'b0;
         end
      end
   end

   // sticky interrupt causes, cleared by reading the cause register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         intCause <= RST_ZERO;
      end else if (clkEn) begin
         intCause <= (rdAcc && accAddr == ADDR_INT_CAUSE) ? RST_ZERO : intCause;
         if (sampleValid && active && !bufOn) begin
            intCause[INT_DRDY_BIT] <= 1'b1;
         end
         if (motionDetect && !fmFlag) begin
            intCause[INT_FM_BIT] <= 1'b1;
         end
         if (bufOn && (wmkHit || (sampleValid && active && bufFull))) begin
            intCause[INT_BUF_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else if (clkEn) begin
         irq <= |(intCause & rwMem[ADDR_INT_MASK[5:0]]);
      end
   end

   function automatic logic [7:0] highByte(input logic [13:0] s);
      highByte = s[SAMPLE_W-1:HIGH_SPLIT];
   endfunction

   function automatic logic [7:0] lowByte(input logic [13:0] s);
      lowByte = {s[HIGH_SPLIT-1:0], 2'b00};
   endfunction

   assign drStatus = {|owFlag, owFlag, |drFlag, drFlag};
   assign bufStatus = {bufOvf, wmkHit, bufCnt[5:0]};
   assign statusByte = bufOn ? bufStatus : drStatus;
   assign fmSrc = {fmFlag, 1'b0, motionDir};

   always_comb begin
      rdByte = RST_ZERO;
      case (accAddr)
         ADDR_STATUS: rdByte = statusByte;
         ADDR_X_HIGH: begin
            if (!bufOn) begin
               rdByte = highByte(xSamp);
            end else if (!bufEmpty) begin
               unique case (bufSel)
                  SEL_XH: rdByte = highByte(headEntry[41:28]);
                  SEL_XL: rdByte = lowByte(headEntry[41:28]);
                  SEL_YH: rdByte = highByte(headEntry[27:14]);
                  SEL_YL: rdByte = lowByte(headEntry[27:14]);
                  SEL_ZH: rdByte = highByte(headEntry[13:0]);
                  SEL_ZL: rdByte = lowByte(headEntry[13:0]);
                  default: rdByte = RST_ZERO;
               endcase
            end
         end
         ADDR_X_LOW: rdByte = lowByte(xSamp);
         ADDR_Y_HIGH: rdByte = highByte(ySamp);
         ADDR_Y_LOW: rdByte = lowByte(ySamp);
         ADDR_Z_HIGH: rdByte = highByte(zSamp);
         ADDR_Z_LOW: rdByte = lowByte(zSamp);
         ADDR_SYS_MODE: rdByte = {7'h00, active};
         ADDR_INT_CAUSE: rdByte = intCause;
         ADDR_ID: rdByte = DEVICE_ID;
         ADDR_ORIENT_STATE: rdByte = orientState;
         ADDR_FM_SRC: rdByte = fmSrc;
         default: rdByte = isWritable(accAddr) ? rwMem[accAddr[5:0]] : RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdData <= RST_ZERO;
      end else if (clkEn) begin
         regRdData <= rdAcc ? rdByte : RST_ZERO;
      end
   end

   a_ptr_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc && accAddr == ADDR_STATUS |=> ptr == ADDR_X_HIGH)
      else $error("pointer did not advance from status");
   a_xhigh_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rdAcc && !bufOn && accAddr == ADDR_X_HIGH |=> regRdData == $past(xSamp[13:6]))
      else $error("x high byte wrong");
   a_ylow_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rdAcc && accAddr == ADDR_Y_LOW |=> regRdData == {$past(ySamp[5:0]), 2'b00})
      else $error("y low byte wrong");
   a_root_pointer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc && bufOn && accAddr == ADDR_X_HIGH |=> ptr == ADDR_X_HIGH)
      else $error("root pointer moved");
   a_seq_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc && !bufOn && !fastRd && accAddr >= ADDR_X_HIGH && accAddr < ADDR_Z_LOW
      |=> ptr == $past(accAddr) + 8'h01)
      else $error("sequential step wrong");
   a_fast_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc && !bufOn && fastRd && accAddr == ADDR_Y_HIGH |=> ptr == ADDR_Z_HIGH)
      else $error("fast read skip wrong");
   a_fast_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc && bufOn && fastRd && accAddr > ADDR_X_HIGH && accAddr <= ADDR_Z_LOW
      |=> ptr == ADDR_STATUS)
      else $error("fast buffered wrap wrong");
   a_cfg_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      acc && accAddr >= ADDR_BUF_SETUP && accAddr <= ADDR_FM_DEB
      |=> ptr == $past(accAddr) + 8'h01)
      else $error("config step wrong");
   a_range_rw: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wrAcc && accAddr == ADDR_RANGE_CFG ##1 rdAcc && accAddr == ADDR_RANGE_CFG
      |=> regRdData == $past(regWrData, 2))
      else $error("range register readback wrong");
   a_trig_reset: assert property (@(posedge clk_sys)
      !rst_n |=> rwMem[ADDR_TRIG_SEL[5:0]] == RST_ZERO)
      else $error("trigger config reset wrong");
   a_fm_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clkEn && latchOn && fmFlag && !(rdAcc && accAddr == ADDR_FM_SRC) |=> fmFlag)
      else $error("latched event lost");
   a_id_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wrAcc && accAddr == ADDR_ID ##1 rdAcc && accAddr == ADDR_ID |=> regRdData == DEVICE_ID)
      else $error("identifier changed by write");

   c_buf_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
      rdAcc && bufOn && accAddr == ADDR_X_HIGH && !bufEmpty && bufLast);
   c_fast_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
      acc && fastRd && !bufOn && accAddr == ADDR_X_HIGH ##1 acc && accAddr == ADDR_Y_HIGH);
   c_fm_latched: cover property (@(posedge clk_sys) disable iff (!rst_n)
      latchOn && fmFlag && !motionDetect ##1 rdAcc && accAddr == ADDR_FM_SRC);
   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
endmodule // accel_reg_autoinc_map

// File: bench/accel_host_model.sv
`timescale 1ns/1ps
module accel_host_model (
   input wire logic clk_sys, // bus clock
   output logic [7:0] regAddr, // register address
   output logic [7:0] regWrData, // write data
   output logic regWr, // write strobe
   output logic regRd, // read strobe
   output logic burst, // access through the device pointer
   input wire logic [7:0] regRdData, // read data
   input wire logic [7:0] ptr // device pointer
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      burst = 1'b0;
   end
   // the reserved gap is never written, so its contents stay untouched
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      if (a == 8'h07 || a == 8'h08) return;
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      burst <= 1'b0;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~v;
   endtask
   // write then read of the same address with no idle cycle between the strobes
   task automatic wrRd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      burst <= 1'b0;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regRd <= 1'b1;
      regWrData <= ~v;
      @(posedge clk_sys);
      regRd <= 1'b0;
      regAddr <= ~a;
      #1;
      q = regRdData;
   endtask
   task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] v,
                     output logic [7:0] p);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      burst <= b;
      @(posedge clk_sys);
      regRd <= 1'b0;
      regAddr <= ~a;
      #1;
      v = regRdData;
      p = ptr;
   endtask
endmodule // accel_host_model

// File: bench/test_accel_reg_autoinc_map.sv
`timescale 1ns/1ps
module test_accel_reg_autoinc_map;
   import accel_reg_pkg::*;
   localparam logic [7:0] TB_ID = 8'h3B; // arbitrary identifier value
   logic clk_sys, rst_n, clkEn, regWr, regRd, burst, sampleValid, motionDetect, irq, bo, fr;
   logic [7:0] regAddr, regWrData, regRdData, ptr, orientState, d, p, ePtr;
   logic [13:0] sampleX, sampleY, sampleZ;
   logic [13:0] sx [3];
   logic [13:0] hx [3];
   logic [5:0] motionDir;
   logic [31:0] seed, r;
   int fails, checks_done;

   accel_reg_autoinc_map #(.DEVICE_ID(TB_ID)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .burst(burst), .regRdData(regRdData), .ptr(ptr), .sampleValid(sampleValid),
      .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ), .motionDetect(motionDetect),
      .motionDir(motionDir), .orientState(orientState), .irq(irq));
   accel_host_model host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .burst(burst), .regRdData(regRdData), .ptr(ptr));

   function automatic logic [31:0] nextRnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] stepOf(input logic [7:0] a, input logic b, input logic f);
      if (a >= 8'h07 || a == 8'h00) return a + 8'h01;
      if (b && a == 8'h01) return 8'h01;
      if (f) return (a == 8'h01) ? 8'h03 : ((a == 8'h03 && !b) ? 8'h05 : 8'h00);
      return (a == 8'h06) ? 8'h00 : a + 8'h01;
   endfunction
   function automatic logic [7:0] byteOf(input logic [13:0] s, input logic hi);
      return hi ? s[13:6] : {s[5:0], 2'b00};
   endfunction
   function automatic logic [7:0] expReset(input logic [7:0] a);
      case (a)
         8'h0D: return TB_ID;
         8'h10: return orientState;
         8'h11: return 8'h80;
         8'h14: return 8'h1A;
         default: return 8'h00;
      endcase
   endfunction

   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // the expected pointer is tracked here from the rules, never read back
   task automatic rdChk(input logic [7:0] a, input logic b, input logic [7:0] exp);
      logic [7:0] cur;
      cur = b ? ePtr : a;
      ePtr = stepOf(cur, bo, fr);
      host.rd(a, b, d, p);
      chkByte(d, exp);
      chkByte(p, ePtr);
   endtask
   task automatic newSample();
      for (int i = 0; i < 3; i++) begin
         r = nextRnd();
         sx[i] = r[13:0];
      end
      @(posedge clk_sys);
      sampleX <= sx[0];
      sampleY <= sx[1];
      sampleZ <= sx[2];
      sampleValid <= 1'b1;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
   endtask
   task automatic end_sim();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      fails++;
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      sampleValid = 1'b0;
      sampleX = 14'h0000;
      sampleY = 14'h0000;
      sampleZ = 14'h0000;
      motionDetect = 1'b0;
      motionDir = 6'h00;
      orientState = 8'h00;
      seed = 32'h7921;
      fails = 0;
      checks_done = 0;
      bo = 1'b0;
      fr = 1'b0;
      repeat (4) @(posedge clk_sys);
      r = nextRnd();
      rst_n <= 1'b1;
      orientState <= r[7:0];
      rdChk(ADDR_RSVD_LO, 1'b0, 8'h00);
      for (int a = 8; a <= 24; a++) rdChk(8'h00, 1'b1, expReset(a[7:0]));
      r = nextRnd();
      host.wr(ADDR_RANGE_CFG, r[7:0]);
      host.wr(ADDR_TRIG_SEL, r[15:8]);
      host.wr(ADDR_ID, r[23:16]);
      host.wr(ADDR_SYS_MODE, 8'hFF);
      rdChk(ADDR_RANGE_CFG, 1'b0, r[7:0]);
      rdChk(ADDR_TRIG_SEL, 1'b0, r[15:8]);
      rdChk(ADDR_ID, 1'b0, TB_ID);
      rdChk(ADDR_SYS_MODE, 1'b0, 8'h00);
      host.wrRd(ADDR_RANGE_CFG, r[31:24], d);
      chkByte(d, r[31:24]);
      host.wrRd(ADDR_ID, r[31:24], d);
      chkByte(d, TB_ID);
      // plain mode: sample, unmasked interrupt, sequential walk
      host.wr(ADDR_SYS_CTRL1, 8'h01);
      host.wr(ADDR_INT_MASK, 8'h01);
      newSample();
      repeat (2) @(posedge clk_sys);
      #1 chkBit(irq, 1'b1);
      rdChk(ADDR_STATUS, 1'b0, 8'h0F);
      for (int i = 0; i < 6; i++) rdChk(8'h00, 1'b1, byteOf(sx[i/2], i % 2 == 0));
      rdChk(ADDR_INT_CAUSE, 1'b0, 8'h01);
      repeat (2) @(posedge clk_sys);
      #1 chkBit(irq, 1'b0);
      host.wr(ADDR_INT_MASK, 8'h00);
      newSample();
      repeat (2) @(posedge clk_sys);
      #1 chkBit(irq, 1'b0);
      rdChk(ADDR_INT_CAUSE, 1'b0, 8'h01);
      // fast read skips low bytes
      host.wr(ADDR_SYS_CTRL1, 8'h03);
      fr = 1'b1;
      rdChk(ADDR_X_HIGH, 1'b0, byteOf(sx[0], 1'b1));
      rdChk(8'h00, 1'b1, byteOf(sx[1], 1'b1));
      rdChk(8'h00, 1'b1, byteOf(sx[2], 1'b1));
      rdChk(ADDR_X_LOW, 1'b0, byteOf(sx[0], 1'b0));
      // buffer: root address returns the head sample and holds the pointer
      host.wr(ADDR_SYS_CTRL1, 8'h01);
      fr = 1'b0;
      host.wr(ADDR_BUF_SETUP, 8'h40);
      bo = 1'b1;
      newSample();
      hx = sx;
      newSample();
      host.rd(ADDR_STATUS, 1'b0, d, p);
      chkByte(d & 8'h3F, 8'h02);
      chkByte(p, 8'h01);
      ePtr = ADDR_X_HIGH;
      for (int i = 0; i < 6; i++) rdChk(8'h00, 1'b1, byteOf(hx[i/2], i % 2 == 0));
      host.wr(ADDR_SYS_CTRL1, 8'h03);
      fr = 1'b1;
      rdChk(ADDR_X_HIGH, 1'b0, byteOf(sx[0], 1'b1));
      host.rd(ADDR_Y_HIGH, 1'b0, d, p);
      chkByte(p, 8'h00);
      host.rd(ADDR_Z_LOW, 1'b0, d, p);
      chkByte(p, 8'h00);
      // fall/motion flag, latched then live
      host.wr(ADDR_FM_CFG, 8'h80);
      r = nextRnd();
      motionDir <= r[5:0];
      motionDetect <= 1'b1;
      @(posedge clk_sys);
      motionDetect <= 1'b0;
      rdChk(ADDR_FM_SRC, 1'b0, {2'b10, r[5:0]});
      rdChk(ADDR_FM_SRC, 1'b0, {2'b00, r[5:0]});
      host.wr(ADDR_FM_CFG, 8'h00);
      motionDetect <= 1'b1;
      rdChk(ADDR_FM_SRC, 1'b0, {2'b10, r[5:0]});
      motionDetect <= 1'b0;
      rdChk(ADDR_FM_SRC, 1'b0, {2'b00, r[5:0]});
      // clock enable low: the read is ignored and the pointer holds
      @(posedge clk_sys);
      clkEn <= 1'b0;
      host.rd(ADDR_ID, 1'b0, d, p);
      chkByte(d, 8'h00);
      chkByte(p, ADDR_FM_THS);
      clkEn <= 1'b1;
      end_sim();
   end
endmodule // test_accel_reg_autoinc_map
